// File: core/pmbus_cmd_ctrl.sv
// fault-clear, write-lock and nonvolatile copy command handling
// assumes a same-clock transaction layer and a same-clock copy engine
`include "pmbus_cmd_consts.svh"

module pmbus_cmd_ctrl
    import pmbus_cmd_pkg::*;
(
    input  wire logic     clk_sys,     // 100 MHz system clock
    input  wire logic     rst,         // synchronous, active high
    input  wire cmd_req_t cmdIn,       // decoded command strobe
    input  wire logic     cmlEvent,    // external comm/memory/logic fault pulse
    input  wire logic     nvmUnlocked, // nonvolatile memory unlocked level
    input  wire logic     copyDone,    // copy engine finished, pulse
    output logic          writeGrant,  // write to this code may proceed
    output logic [15:0]   readData,    // read answer
    output logic          readValid,   // read answer strobe
    output logic          copyReq,     // copy request, held until done
    output copy_op_t      copyOp,      // which copy
    output logic [3:0]    copyPage,    // nonvolatile page of the copy
    output logic [7:0]    writeLock,   // lock register value
    output logic [15:0]   statusWord   // status word value
);

    logic [7:0]  lock_q, lock_d;
    logic        cml_q, cml_d;
    logic [15:0] rdata_q, rdata_d;
    logic        rvalid_q, rvalid_d;
    ctrl_state_t state_q, state_d;
    copy_op_t    op_q, op_d;
    logic [3:0]  page_q, page_d;
    logic        isWrite, isRead, allowed, reject, copyCmd;

    // strictest bit checked first so several set bits act as the highest
    // strictest lock wins
    function automatic logic lockAllows(input logic [7:0] lk, input logic [7:0] code);
        logic ok;
        ok = 1'b1;
        if (lk[`LOCK_ALL_BIT])
            ok = (code == `CMD_WRITE_LOCK);
        else if (lk[`LOCK_CTRL_BIT])
            ok = (code == `CMD_WRITE_LOCK) || (code == `CMD_OPERATION) ||
                 (code == `CMD_PAGE);
        else if (lk[`LOCK_VOUT_BIT])
            ok = (code == `CMD_WRITE_LOCK) || (code == `CMD_OPERATION) ||
                 (code == `CMD_PAGE) || (code == `CMD_ON_OFF_CFG) ||
                 (code == `CMD_VOUT_COMMAND);
        return ok;
    endfunction : lockAllows

    // classify the incoming strobe
    always_comb
    begin
        isWrite    = cmdIn.valid && cmdIn.write;
        isRead     = cmdIn.valid && !cmdIn.write;
        allowed    = lockAllows(lock_q, cmdIn.code);
        writeGrant = isWrite && allowed;
        reject     = isWrite && !allowed;
        copyCmd    = writeGrant && cmdIn.noData &&
                     ((cmdIn.code == `CMD_RESTORE_FACT) ||
                      (cmdIn.code == `CMD_STORE_USER) ||
                      (cmdIn.code == `CMD_RESTORE_USER));
    end

    // lock register next value
    always_comb
    begin
        lock_d = lock_q;
        if (writeGrant && !cmdIn.noData && cmdIn.code == `CMD_WRITE_LOCK)
            lock_d = cmdIn.data & `LOCK_RW_MASK;
    end

    // copy sequencer; a copy while one runs is refused, since the engine
    // holds operating memory and a second request would race it
    always_comb
    begin
        state_d = state_q;
        op_d    = op_q;
        page_d  = page_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (copyCmd)
                begin
                    if (cmdIn.code == `CMD_RESTORE_FACT)
                    begin
                        state_d = ST_COPY;
                        op_d    = COPY_LOAD_FACTORY;
                        page_d  = `PAGE_FACTORY;
                    end
                    else if (cmdIn.code == `CMD_RESTORE_USER)
                    begin
                        state_d = ST_COPY;
                        op_d    = COPY_LOAD_USER;
                        page_d  = `PAGE_USER;
                    end
                    // store to page 1 when unlocked
                    else if (nvmUnlocked)
                    begin
                        state_d = ST_COPY;
                        op_d    = COPY_STORE_USER;
                        page_d  = `PAGE_USER;
                    end
                end
            end
            ST_COPY:
            begin
                if (copyDone)
                begin
                    state_d = ST_IDLE;
                    op_d    = COPY_NONE;
                    page_d  = `PAGE_FACTORY;
                end
            end
        endcase
    end

    // sticky fault flag; a new fault in the clearing cycle survives
    always_comb
    begin
        logic setCml;
        logic clrCml;
        setCml = cmlEvent || reject ||
                 (copyCmd && state_q == ST_COPY) ||
                 (copyCmd && state_q == ST_IDLE && cmdIn.code == `CMD_STORE_USER &&
                  !nvmUnlocked);
        clrCml = writeGrant && cmdIn.noData && cmdIn.code == `CMD_CLEAR_FAULTS;
        cml_d = setCml || (cml_q && !clrCml);
    end

    // read answers, one cycle after the strobe
    always_comb
    begin
        rvalid_d = isRead;
        rdata_d  = 16'h0000;
        if (isRead)
        begin
            if (cmdIn.code == `CMD_WRITE_LOCK)
                rdata_d = {8'h00, lock_q};
            else if (cmdIn.code == `CMD_STATUS_BYTE)
                rdata_d = {8'h00, statusWord[7:0]};
            else if (cmdIn.code == `CMD_STATUS_WORD)
                rdata_d = statusWord;
        end
    end

    // register everything on every edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lock_q   <= `LOCK_RESET;
            cml_q    <= 1'b0;
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
            state_q  <= ST_IDLE;
            op_q     <= COPY_NONE;
            page_q   <= `PAGE_FACTORY;
        end
        else
        begin
            lock_q   <= lock_d;
            cml_q    <= cml_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            state_q  <= state_d;
            op_q     <= op_d;
            page_q   <= page_d;
        end
    end

    // only bit 1 is implemented; all others read zero
    assign statusWord = `STATUS_RESET | (16'(cml_q) << `STATUS_CML_BIT);
    assign writeLock  = lock_q;
    assign readData   = rdata_q;
    assign readValid  = rvalid_q;
    assign copyReq    = (state_q == ST_COPY);
    assign copyOp     = op_q;
    assign copyPage   = page_q;

    a_clear_faults: assert property (@(posedge clk_sys) disable iff (rst)
        (writeGrant && cmdIn.noData && cmdIn.code == `CMD_CLEAR_FAULTS && !cmlEvent)
        |=> (statusWord == 16'h0000))
        else $error("fault clear left a status bit set");

    a_lock_all: assert property (@(posedge clk_sys) disable iff (rst)
        (writeLock[7] && cmdIn.valid && cmdIn.write && cmdIn.code != `CMD_WRITE_LOCK)
        |-> !writeGrant)
        else $error("write granted under full lock");

    a_lock_ctrl: assert property (@(posedge clk_sys) disable iff (rst)
        (writeLock[7:6] == 2'b01 && cmdIn.valid && cmdIn.write)
        |-> (writeGrant == (cmdIn.code == `CMD_WRITE_LOCK ||
             cmdIn.code == `CMD_OPERATION || cmdIn.code == `CMD_PAGE)))
        else $error("control lock grant wrong");

    a_lock_vout: assert property (@(posedge clk_sys) disable iff (rst)
        (writeLock[7:5] == 3'b001 && cmdIn.valid && cmdIn.write &&
         cmdIn.code == `CMD_STORE_USER) |-> !writeGrant)
        else $error("store granted under voltage lock");

    a_lock_resv: assert property (@(posedge clk_sys) disable iff (rst)
        (writeLock[4:0] == 5'h00) && (!readValid || readData[15:8] == 8'h00))
        else $error("reserved lock bits nonzero");

    a_factory_load: assert property (@(posedge clk_sys) disable iff (rst)
        (copyCmd && cmdIn.code == `CMD_RESTORE_FACT && !copyReq)
        |=> (copyReq && copyOp == COPY_LOAD_FACTORY && copyPage == 4'h0))
        else $error("factory restore not started");

    a_store_user: assert property (@(posedge clk_sys) disable iff (rst)
        (copyCmd && cmdIn.code == `CMD_STORE_USER && nvmUnlocked && !copyReq)
        |=> (copyOp == COPY_STORE_USER && copyPage == 4'h1))
        else $error("store user not started");

    a_store_locked: assert property (@(posedge clk_sys) disable iff (rst)
        (cmdIn.valid && cmdIn.code == `CMD_STORE_USER && !nvmUnlocked && !copyReq)
        |=> !copyReq)
        else $error("store started while memory locked");

    a_user_load: assert property (@(posedge clk_sys) disable iff (rst)
        (copyCmd && cmdIn.code == `CMD_RESTORE_USER && !copyReq)
        |=> (copyOp == COPY_LOAD_USER && copyPage == 4'h1))
        else $error("user restore not started");

    a_cml_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        (statusWord[1] && !(writeGrant && cmdIn.noData &&
         cmdIn.code == `CMD_CLEAR_FAULTS)) |=> statusWord[1])
        else $error("fault flag dropped without clear");

    a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
        cmlEvent |=> statusWord[1])
        else $error("fault event lost");

endmodule : pmbus_cmd_ctrl

// File: core/pmbus_cmd_consts.svh
// command codes, field positions, reset values for the fault/protect/store block
// assumes inclusion by bare name from the controller
`ifndef PMBUS_CMD_CONSTS_SVH
`define PMBUS_CMD_CONSTS_SVH

`define CMD_PAGE          8'h00
`define CMD_OPERATION     8'h01
`define CMD_ON_OFF_CFG    8'h02
`define CMD_CLEAR_FAULTS  8'h03
`define CMD_WRITE_LOCK    8'h10
`define CMD_RESTORE_FACT  8'h12
`define CMD_STORE_USER    8'h15
`define CMD_RESTORE_USER  8'h16
`define CMD_VOUT_COMMAND  8'h21
`define CMD_STATUS_BYTE   8'h78
`define CMD_STATUS_WORD   8'h79

`define LOCK_ALL_BIT      7
`define LOCK_CTRL_BIT     6
`define LOCK_VOUT_BIT     5
`define LOCK_RW_MASK      8'hE0
`define LOCK_RESET        8'h00

`define STATUS_CML_BIT    1
`define STATUS_RESET      16'h0000

`define PAGE_FACTORY      4'h0
`define PAGE_USER         4'h1

`endif

// File: core/pmbus_cmd_pkg.sv
// types shared by the fault/protect/store controller and its users
// assumes the transaction layer delivers one decoded command per cycle
package pmbus_cmd_pkg;

    // one decoded transaction from the bus layer
    typedef struct packed {
        logic       valid;   // one-cycle strobe
        logic       write;   // 1 = write direction, 0 = read
        logic       noData;  // send-byte form
        logic [7:0] code;    // command code
        logic [7:0] data;    // first data byte of a write
    } cmd_req_t;

    // nonvolatile copy operations
    typedef enum logic [1:0] {
        COPY_NONE,
        COPY_LOAD_FACTORY,
        COPY_LOAD_USER,
        COPY_STORE_USER
    } copy_op_t;

    typedef enum logic {
        ST_IDLE,
        ST_COPY
    } ctrl_state_t;

endpackage : pmbus_cmd_pkg

// File: sim/copy_engine_model.sv
// stand-in for the copy engine: answers each copy request with one done pulse
// assumes copyReq stays high until the edge after that pulse
module copy_engine_model (
    input  wire logic clk_sys,  // system clock
    input  wire logic rst,      // synchronous reset
    input  wire logic copyReq,  // copy request level
    input  wire logic slow,     // long copy when high
    output logic      copyDone  // one-cycle done pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt_q;
    logic seen_q;

    // one pulse per request; seen_q stops a second pulse while copyReq falls
    always_ff @(posedge clk_sys)
    begin
        copyDone <= 1'b0;
        if (rst || !copyReq)
        begin
            cnt_q  <= 0;
            seen_q <= 1'b0;
        end
        else if (!seen_q)
        begin
            cnt_q <= cnt_q + 1;
            if (cnt_q >= (slow ? 12 : 1))
            begin
                copyDone <= 1'b1;
                seen_q   <= 1'b1;
            end
        end
    end
endmodule : copy_engine_model

// File: sim/pmbus_fault_protect_store_cmds_tb.sv
// bench for the fault-clear, write-lock and copy command controller
// assumes one clock; a reference model is compared with every output each cycle, readData only when a read answer is due, writeGrant only out of reset
module pmbus_fault_protect_store_cmds_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmbus_cmd_pkg::*;
    logic        clk_sys, rst, cmlEvent, nvmUnlocked, copyDone, slow;
    logic        writeGrant, readValid, copyReq;
    cmd_req_t    cmdIn, c;
    copy_op_t    copyOp, op;
    logic [15:0] readData, statusWord;
    logic [7:0]  writeLock;
    logic [3:0]  copyPage;
    int          n_fail, n_checks, lk, st, rd, rv, bz, pg, sv, clr, k;
    logic [31:0] r;
    logic [7:0]  codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h12, 8'h15, 8'h16,
                                8'h21, 8'h78, 8'h79};

    pmbus_cmd_ctrl u_pmbus_cmd_ctrl (.clk_sys(clk_sys), .rst(rst), .cmdIn(cmdIn),
        .cmlEvent(cmlEvent), .nvmUnlocked(nvmUnlocked), .copyDone(copyDone),
        .writeGrant(writeGrant), .readData(readData), .readValid(readValid),
        .copyReq(copyReq), .copyOp(copyOp), .copyPage(copyPage), .writeLock(writeLock),
        .statusWord(statusWord));
    copy_engine_model u_copy_engine_model (.clk_sys(clk_sys), .rst(rst), .copyReq(copyReq),
        .slow(slow), .copyDone(copyDone));

    // clock, 10 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic bit ok(input logic [7:0] cd);
        return lk[7] ? cd == 8'h10 : lk[6] ? (cd <= 8'h01 || cd == 8'h10) :
               lk[5] ? (cd <= 8'h02 || cd == 8'h10 || cd == 8'h21) : 1'b1;
    endfunction : ok

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic cmd(input logic w, input logic n, input logic [7:0] cd, input logic [7:0] d);
        @(negedge clk_sys);
        cmdIn = {1'b1, w, n, cd, d};
    endtask : cmd

    task automatic idle(input int m);
        repeat (m)
        begin
            @(negedge clk_sys);
            cmdIn = '0;
        end
    endtask : idle

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // grant is combinational, so it is judged against the lock before the edge
    always @(negedge clk_sys)
    begin
        #2;
        if (!rst)
            chk(16'(writeGrant), 16'(cmdIn.valid && cmdIn.write && ok(cmdIn.code)));
    end

    // reference model steps on each edge; set wins over clear like the design
    always @(posedge clk_sys)
    begin
        c = cmdIn;
        sv = int'(cmlEvent);
        clr = 0;
        rv = 0;
        if (rst)
        begin
            {lk, st, bz, pg, sv} = '0;
            op = COPY_NONE;
        end
        else if (c.valid && !c.write)
        begin
            rv = 1;
            rd = c.code == 8'h79 ? st : c.code == 8'h78 ? st & 255 : c.code == 8'h10 ? lk : 0;
        end
        else if (c.valid && !ok(c.code))
            sv = 1;
        else if (c.valid && c.code == 8'h10 && !c.noData)
            lk = c.data & 8'hE0;
        else if (c.valid && c.noData && c.code == 8'h03)
            clr = 1;
        else if (c.valid && c.noData && (c.code == 8'h12 || c.code == 8'h15 || c.code == 8'h16))
        begin
            if (bz || (c.code == 8'h15 && !nvmUnlocked))
                sv = 1;
            else
            begin
                bz = 1;
                pg = int'(c.code != 8'h12);
                op = c.code == 8'h12 ? COPY_LOAD_FACTORY : c.code == 8'h16 ? COPY_LOAD_USER
                                                                         : COPY_STORE_USER;
            end
        end
        if (copyDone && !rst)
        begin
            bz = 0;
            pg = 0;
            op = COPY_NONE;
        end
        st = sv ? 2 : clr ? 0 : st;
        #1;
        chk({8'h00, writeLock}, 16'(lk));
        chk(statusWord, 16'(st));
        chk(16'(readValid), 16'(rv));
        if (rv) chk(readData, 16'(rd));
        chk(16'(copyReq), 16'(bz));
        chk(16'(copyOp), 16'(op));
        chk(16'(copyPage), 16'(pg));
    end

    // the run should need about 16 us; cut a hang well beyond that
    initial
    begin
        #500000;
        n_fail++;
        end_of_test();
    end

    initial
    begin
        {cmdIn, cmlEvent, nvmUnlocked, slow, n_fail, n_checks} = '0;
        rst = 1'b1;
        void'($urandom(32'hCD80));
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        // each lock level, strictest first, then readback and clear
        cmd(1, 0, 8'h10, 8'hFF); cmd(1, 1, 8'h03, 0); cmd(1, 0, 8'h01, 0);
        cmd(1, 0, 8'h10, 8'h5F); cmd(1, 0, 8'h01, 0); cmd(1, 0, 8'h02, 0);
        cmd(1, 0, 8'h10, 8'h20); cmd(1, 0, 8'h21, 0); cmd(1, 1, 8'h12, 0);
        cmd(0, 0, 8'h10, 0); cmd(0, 0, 8'h79, 0); cmd(0, 0, 8'h78, 0);
        cmd(1, 0, 8'h10, 0); cmd(1, 1, 8'h03, 0); cmd(0, 0, 8'h79, 0);
        idle(2);
        $display("test lock levels done");
        // every copy, a locked store, and a copy refused while busy
        for (int i = 0; i < 5; i++)
        begin
            // host unlocks before store; the last store finds it locked
            nvmUnlocked = i != 4;
            slow = i[0];
            cmd(1, 1, codes[5 + i % 3], 0);
            cmd(1, 1, 8'h16, 0);
            idle(1);
            for (k = 0; k < 50 && copyReq !== 1'b0; k++) idle(1);
            chk(16'(copyReq), 16'h0000);
            cmd(1, 1, 8'h03, 0);
        end
        idle(2);
        $display("test copies done");
        // random traffic with faults, unlock changes and a rare mid-run reset
        repeat (1500)
        begin
            @(negedge clk_sys);
            r = $urandom;
            cmlEvent = r[31:27] == 5'h00;
            nvmUnlocked = r[26];
            slow = r[25];
            rst = r[24:15] == 10'h000;
            cmdIn = {r[13], r[12], r[11] | r[10], codes[r[9:0] % 11], r[7:0]};
        end
        @(negedge clk_sys);
        rst = 1'b0;
        cmlEvent = 1'b0;
        idle(20);
        $display("test random done");
        end_of_test();
    end
endmodule : pmbus_fault_protect_store_cmds_tb
